// File: dv/sarseq_analog_model.sv
// Purpose: comparator side of the converter
// Assumes: each input sits at zero or full scale
// Notes:   output toggles outside sample and conversion so nothing leans on it
`timescale 1ns/1ps
`default_nettype none
module sarseq_analog_model (
  // clock
  input  wire logic                       aclk,
  // converter side
  input  wire sarseq_pkg::sarseq_analog_t analog,
  input  wire logic [7:0]                 full_mask,
  output logic                            sar_compare
);
  import sarseq_pkg::*;
  initial sar_compare = 1'b0;
  // held steady through conversion, the sync flops need it
  always @(posedge aclk) begin
    if (analog.sample) begin
      sar_compare <= full_mask[analog.channel];
    end else if (!analog.sar_valid) begin
      sar_compare <= !sar_compare;
    end
  end
endmodule // sarseq_analog_model
`default_nettype wire

// File: dv/sarseq_chk.sv
// Purpose: port checks for the converter sequencer
// Assumes: status outputs registered one cycle after their cause; ready outputs combinational
// Notes:   bound to every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module sarseq_chk (
  // clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // bus handshakes
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  // power and analog side
  input wire logic                       idle_mode,
  input wire logic                       power_down,
  input wire logic                       conv_irq_enable,
  input wire sarseq_pkg::sarseq_power_t  power,
  input wire sarseq_pkg::sarseq_analog_t analog
);
  import sarseq_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  irq_mask_a: assert property (!conv_irq_enable |=> !power.irq)
    else $error("interrupt raised while disabled");
  irq_en_a: assert property (power.irq |-> $past(conv_irq_enable))
    else $error("interrupt without enable");
  wake_idle_a: assert property (power.wake |-> power.irq && $past(idle_mode))
    else $error("wake without idle interrupt");
  pd_off_a: assert property (power_down |=> !power.powered)
    else $error("powered in power-down");
  pd_stop_a: assert property (power_down [*3] |-> !analog.sample && !analog.sar_valid)
    else $error("converter active in power-down");
  one_phase_a: assert property (!(analog.sample && analog.sar_valid))
    else $error("sample and convert together");
  conv_order_a: assert property ($rose(analog.sar_valid) |-> $past(analog.sample))
    else $error("convert without sample phase");
  samp_min_a: assert property ($rose(analog.sample) |-> analog.sample [*4])
    else $error("sample phase too short");
endmodule // sarseq_chk
bind sarseq_top sarseq_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .idle_mode, .power_down,
  .conv_irq_enable, .power, .analog);
`default_nettype wire

// File: dv/tb_top.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: inputs 3, 5, 7 at full scale, the rest at zero
// Notes:   register checks first, then timing rows, awkward cases after
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sarseq_pkg::*;
  typedef struct {
    logic [2:0] dv;
    logic [3:0] sl;
    logic [2:0] ch;
    int         es;
    int         ec;
    logic [7:0] hi;
  } sarseq_row_t;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        idle_mode = 1'b0, power_down = 1'b0, conv_irq_enable = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        sar_compare;
  sarseq_power_t  power;
  sarseq_analog_t analog;
  int          bad_count = 0, num_checks = 0, cs, cc;
  // clamp of sample_len+1 to 2..15 is folded into es
  sarseq_row_t rows [8] = '{'{3'h0, 4'h0, 3'h2, 4, 24, 8'h00},
    '{3'h1, 4'h7, 3'h3, 32, 48, 8'hff}, '{3'h2, 4'h1, 3'h4, 12, 72, 8'h00},
    '{3'h3, 4'h2, 3'h5, 24, 96, 8'hff}, '{3'h4, 4'hf, 3'h6, 180, 144, 8'h00},
    '{3'h5, 4'he, 3'h7, 240, 192, 8'hff}, '{3'h6, 4'h3, 3'h2, 96, 288, 8'h00},
    '{3'h7, 4'hf, 3'h3, 480, 384, 8'hff}};
  always #2.5 aclk = !aclk;
  sarseq_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .idle_mode,
    .power_down, .conv_irq_enable, .power, .analog, .sar_compare);
  sarseq_analog_model u_ana (.aclk, .analog, .full_mask(8'ha8), .sar_compare);
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo;
    bad_count++;
    $display("ERROR at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
    summarize;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] b);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 99);
    if (n >= 99) tmo;
    b = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] b);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 99);
    if (n >= 99) tmo;
    d = s_axi_rdata;
    b = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // counts edges spent in each phase of one conversion
  task automatic meas(output int s, output int c);
    int n;
    n = 0;
    s = 0;
    c = 0;
    while (!analog.sample && n < 99) begin @(posedge aclk); n++; end
    while (analog.sample && s < 999) begin @(posedge aclk); s++; end
    while (analog.sar_valid && c < 999) begin @(posedge aclk); c++; end
    if (n >= 99 || s >= 999 || c >= 999) tmo;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CONTROL, v, r);
    chk(v, 32'h10);
    rd(ADDR_TIMING, v, r);
    chk(v, 32'h0);
    wr(ADDR_CONTROL, 8'h40, r);
    rd(ADDR_CONTROL, v, r);
    chk(v & 32'hef, 32'h0);
    wr(12'h100, 8'h55, r);
    chk(r, RESP_SLVERR);
    rd(12'h100, v, r);
    chk(v, 32'h0);
    chk(r, RESP_SLVERR);
    $display("test registers done");
    foreach (rows[i]) begin
      wr(ADDR_TIMING, {rows[i].dv, 1'b0, rows[i].sl}, r);
      wr(ADDR_CONTROL, {4'h8, rows[i].ch, 1'b1}, r);
      meas(cs, cc);
      chk(cs, rows[i].es);
      chk(cc, rows[i].ec);
      chk(analog.channel, rows[i].ch);
      repeat (2) @(posedge aclk);
      chk(power.irq, 1'b1);
      rd(ADDR_CONTROL, v, r);
      chk(v & 32'hef, {24'h0, 4'hc, rows[i].ch, 1'b0});
      rd(ADDR_RES_HIGH, v, r);
      chk(v, rows[i].hi);
      rd(ADDR_RES_LOW, v, r);
      chk(v & 32'h3, rows[i].hi[1:0]);
      wr(ADDR_CONTROL, {4'h8, rows[i].ch, 1'b0}, r);
      rd(ADDR_CONTROL, v, r);
      chk(v[6], 1'b0);
    end
    $display("test timing rows done");
    wr(ADDR_TIMING, 8'hef, r);
    wr(ADDR_CONTROL, 8'h85, r);
    repeat (40) @(posedge aclk);
    chk(analog.sample, 1'b1);
    wr(ADDR_CONTROL, 8'h84, r);
    repeat (3) @(posedge aclk);
    chk(analog.sample | analog.sar_valid, 1'b0);
    rd(ADDR_CONTROL, v, r);
    chk(v & 32'hef, 32'h84);
    rd(ADDR_RES_HIGH, v, r);
    chk(v, 32'hff);
    rd(ADDR_STATUS, v, r);
    chk(v, 32'h4);
    $display("test abort done");
    wr(ADDR_TIMING, 8'h00, r);
    wr(ADDR_RES_HIGH, 8'hff, r);
    wr(ADDR_RES_LOW, 8'h02, r);
    wr(ADDR_CONTROL, 8'ha7, r);
    repeat (99) @(posedge aclk);
    rd(ADDR_CONTROL, v, r);
    chk(v & 32'hef, 32'he7);
    chk(analog.sample | analog.sar_valid, 1'b1);
    wr(ADDR_CONTROL, 8'ha6, r);
    // a compare hit in the stopping write's cycle wins over the clear
    wr(ADDR_CONTROL, 8'ha6, r);
    wr(ADDR_RES_LOW, 8'h03, r);
    wr(ADDR_CONTROL, 8'ha7, r);
    repeat (99) @(posedge aclk);
    rd(ADDR_CONTROL, v, r);
    chk(v & 32'hef, 32'ha7);
    wr(ADDR_CONTROL, 8'h27, r);
    repeat (40) @(posedge aclk);
    chk(analog.sample | analog.sar_valid, 1'b0);
    chk(power.powered, 1'b0);
    $display("test compare done");
    idle_mode <= 1'b1;
    wr(ADDR_CONTROL, 8'h8f, r);
    meas(cs, cc);
    repeat (2) @(posedge aclk);
    chk(power.wake, 1'b1);
    conv_irq_enable <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(power.irq, 1'b0);
    conv_irq_enable <= 1'b1;
    idle_mode <= 1'b0;
    power_down <= 1'b1;
    wr(ADDR_CONTROL, 8'h8f, r);
    repeat (40) @(posedge aclk);
    chk(analog.sample | analog.sar_valid, 1'b0);
    chk(power.powered, 1'b0);
    power_down <= 1'b0;
    $display("test power modes done");
    wr(ADDR_CONTROL, 8'h8f, r);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CONTROL, v, r);
    chk(v, 32'h10);
    chk(analog.sample, 1'b0);
    $display("test second reset done");
    summarize;
  end
endmodule // tb_top
`default_nettype wire

// File: logic/sarseq_pkg.sv
// Purpose: shared constants and types for the converter sequencer
// Assumes: 32-bit axi4-lite register bus, byte offsets are four times the register index
// Notes:   register indices keep the printed numbering
package sarseq_pkg;

  // register indices and byte addresses
  localparam logic [7:0]  IDX_CONTROL   = 8'h93;
  localparam logic [7:0]  IDX_TIMING    = 8'h94;
  localparam logic [7:0]  IDX_RES_LOW   = 8'h96;
  localparam logic [7:0]  IDX_RES_HIGH  = 8'h97;
  localparam logic [7:0]  IDX_STATUS    = 8'ha0;
  localparam logic [11:0] ADDR_CONTROL  = {2'h0, IDX_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_TIMING   = {2'h0, IDX_TIMING, 2'h0};
  localparam logic [11:0] ADDR_RES_LOW  = {2'h0, IDX_RES_LOW, 2'h0};
  localparam logic [11:0] ADDR_RES_HIGH = {2'h0, IDX_RES_HIGH, 2'h0};
  localparam logic [11:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};

  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h10;
  localparam logic [7:0] RST_TIMING  = 8'h00;

  // control field positions
  localparam int CTL_ON   = 7;
  localparam int CTL_IRQ  = 6;
  localparam int CTL_CMP  = 5;
  localparam int CTL_CH_LO = 1;
  localparam int CTL_GO   = 0;
  // timing field positions
  localparam int TIM_DIV_LO = 5;

  // timing counts, in conversion-clock periods
  localparam logic [3:0] SAMPLE_MIN  = 4'h2;
  localparam logic [3:0] SAMPLE_MAX  = 4'hf;
  localparam logic [3:0] CONV_PERIODS = 4'hc;
  localparam logic [3:0] RESULT_BITS = 4'ha;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SARSEQ_IDLE, SARSEQ_SAMPLE, SARSEQ_CONVERT} sarseq_state_t;

  typedef struct packed {
    logic [2:0] channel;
    logic       sample;
    logic       sar_valid;
  } sarseq_analog_t;

  typedef struct packed {
    logic       powered;
    logic       irq;
    logic       wake;
  } sarseq_power_t;

endpackage

// File: logic/sarseq_top.sv
// Purpose: sequencer for a 10-bit successive-approximation converter, six inputs
// Assumes: comparator result arrives from the analog side unsynchronised and is synchronised twice here
// Notes:   registers over axi4-lite; one write and one read under way at a time
//
// Functional notes
// - converter runs only while converter_on is set
// - writing go starts conversion or comparing
// - hardware clears go when conversion ends
// - clearing go mid-conversion aborts at once
// - completion loads result and sets irq flag
// - interrupt request follows flag and enable
// - irq flag set by hardware, software clears
// - compare needs compare_enable and converter_on
// - compare flags only when input exceeds threshold
// - compare repeats; go never cleared by hardware
// - channel_select 010..111 picks inputs 2..7
// - only one channel connected at a time
// - conv_clock_div sets conversion clock period
// - sample time sample_len+1, clamped 2..15
// - runs in idle, interrupt wakes idle
// - power-down disables converter and comparator
// - result is 10-bit unsigned single-ended
// - conversion takes twelve periods plus sample
// - result split high 9..2, low 1..0
`timescale 1ns/1ps
`default_nettype none
module sarseq_top (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // power modes and interrupt controller
  input  wire logic                    idle_mode,
  input  wire logic                    power_down,
  input  wire logic                    conv_irq_enable,
  output sarseq_pkg::sarseq_power_t    power,
  // analog side
  output sarseq_pkg::sarseq_analog_t   analog,
  input  wire logic                    sar_compare
);
  import sarseq_pkg::*;

  logic [7:0]    converter_control;
  logic [2:0]    conv_clock_div;
  logic [3:0]    sample_len;
  logic [9:0]    result;
  sarseq_state_t state;
  logic [4:0]    div_cnt;
  logic          tick;
  logic [3:0]    phase_cnt;
  logic [9:0]    sar_reg;
  logic [9:0]    trial_bit;
  logic [1:0]    cmp_sync;
  logic          active;
  logic          done_conv;
  logic          done_cmp;
  logic          cmp_hit;
  logic [4:0]    div_last;
  logic [3:0]    sample_last;
  logic [3:0]    sample_raw;

  // bus handshake state
  logic          aw_held;
  logic          w_held;
  logic [11:0]   aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          wr_fire;
  logic          sw_go_set;
  logic          sw_go_clr;
  logic          sw_irq_clr;

  wire compare_mode = converter_control[CTL_CMP];
  wire go_flag      = converter_control[CTL_GO];

  // no power-down, converter on; a stray power-down kills the sequence at once
  assign active = converter_control[CTL_ON] && !power_down;

  // conversion clock divider; period in system clocks is div_last+1
  always_comb begin
    unique case (conv_clock_div)
      3'h0: div_last = 5'h01;
      3'h1: div_last = 5'h03;
      3'h2: div_last = 5'h05;
      3'h3: div_last = 5'h07;
      3'h4: div_last = 5'h0b;
      3'h5: div_last = 5'h0f;
      3'h6: div_last = 5'h17;
      3'h7: div_last = 5'h1f;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state == SARSEQ_IDLE || div_cnt == div_last) begin
      div_cnt <= 5'h00;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end
  assign tick = (state != SARSEQ_IDLE) && (div_cnt == div_last);

  // sample length clamp, counted as last index
  assign sample_raw = (sample_len == SAMPLE_MAX) ? SAMPLE_MAX : sample_len + 4'h1;
  always_comb begin
    if (sample_raw < SAMPLE_MIN) begin
      sample_last = SAMPLE_MIN - 4'h1;
    end else begin
      sample_last = sample_raw - 4'h1;
    end
  end

  // two flip-flops on the comparator output from the analog domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_sync <= 2'h0;
    end else begin
      cmp_sync <= {cmp_sync[0], sar_compare};
    end
  end

  // sequencer: sample for sample_last+1 periods, then 12 periods:
  // ten bit trials plus two settling periods
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= SARSEQ_IDLE;
      phase_cnt <= 4'h0;
      sar_reg   <= 10'h000;
      trial_bit <= 10'h000;
    end else if (!active || !go_flag) begin
      state     <= SARSEQ_IDLE;
      phase_cnt <= 4'h0;
    end else begin
      unique case (state)
        SARSEQ_IDLE: begin
          state     <= SARSEQ_SAMPLE;
          phase_cnt <= 4'h0;
        end
        SARSEQ_SAMPLE: if (tick) begin
          if (phase_cnt == sample_last) begin
            state     <= SARSEQ_CONVERT;
            phase_cnt <= 4'h0;
            sar_reg   <= 10'h200;
            trial_bit <= 10'h200;
          end else begin
            phase_cnt <= phase_cnt + 4'h1;
          end
        end
        SARSEQ_CONVERT: if (tick) begin
          if (phase_cnt < RESULT_BITS) begin
            // keep the trial bit if the analog level is at or above it
            sar_reg   <= (cmp_sync[1] ? sar_reg : (sar_reg & ~trial_bit))
                         | (trial_bit >> 1);
            trial_bit <= trial_bit >> 1;
          end
          if (phase_cnt == CONV_PERIODS - 4'h1) begin
            state     <= compare_mode ? SARSEQ_SAMPLE : SARSEQ_IDLE;
            phase_cnt <= 4'h0;
          end else begin
            phase_cnt <= phase_cnt + 4'h1;
          end
        end
        default: state <= SARSEQ_IDLE;
      endcase
    end
  end

  wire finish = active && go_flag && state == SARSEQ_CONVERT && tick
                && phase_cnt == CONV_PERIODS - 4'h1;
  assign done_conv = finish && !compare_mode;
  assign done_cmp  = finish && compare_mode;
  assign cmp_hit   = done_cmp && (sar_reg > result);

  // analog side drive; a single channel code so only one input is switched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog <= '0;
    end else begin
      analog.channel   <= converter_control[CTL_CH_LO +: 3];
      analog.sample    <= active && state == SARSEQ_SAMPLE;
      analog.sar_valid <= active && state == SARSEQ_CONVERT;
    end
  end

  // axi4-lite write path: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end
  assign wr_fire = aw_held && w_held;

  wire wr_ok = aw_addr == ADDR_CONTROL || aw_addr == ADDR_TIMING ||
               aw_addr == ADDR_RES_LOW || aw_addr == ADDR_RES_HIGH;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  wire ctl_wr = wr_fire && aw_addr == ADDR_CONTROL && w_strb[0];
  assign sw_go_set  = ctl_wr && w_data[CTL_GO];
  assign sw_go_clr  = ctl_wr && !w_data[CTL_GO];
  assign sw_irq_clr = ctl_wr && !w_data[CTL_IRQ];

  // control register; writing 1 to the irq flag does nothing, hardware set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_control <= RST_CONTROL;
    end else begin
      if (ctl_wr) begin
        converter_control[CTL_ON]             <= w_data[CTL_ON];
        converter_control[CTL_CMP]            <= w_data[CTL_CMP];
        converter_control[CTL_CH_LO +: 3]     <= w_data[CTL_CH_LO +: 3];
      end
      if (done_conv || cmp_hit) begin
        converter_control[CTL_IRQ] <= 1'b1;
      end else if (sw_irq_clr) begin
        converter_control[CTL_IRQ] <= 1'b0;
      end
      if (sw_go_set) begin
        converter_control[CTL_GO] <= 1'b1;
      end else if (sw_go_clr || done_conv) begin
        converter_control[CTL_GO] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_clock_div <= RST_TIMING[7:5];
      sample_len     <= RST_TIMING[3:0];
    end else if (wr_fire && aw_addr == ADDR_TIMING && w_strb[0]) begin
      conv_clock_div <= w_data[TIM_DIV_LO +: 3];
      sample_len     <= w_data[3:0];
    end
  end

  // result registers double as compare threshold; completion wins over a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= 10'h000;
    end else if (done_conv) begin
      result <= sar_reg;
    end else if (wr_fire && w_strb[0]) begin
      if (aw_addr == ADDR_RES_HIGH) begin
        result[9:2] <= w_data[7:0];
      end else if (aw_addr == ADDR_RES_LOW) begin
        result[1:0] <= w_data[1:0];
      end
    end
  end

  // axi4-lite read path
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CONTROL:  s_axi_rdata <= {24'h0, converter_control};
        ADDR_TIMING:   s_axi_rdata <= {24'h0, conv_clock_div, 1'b0, sample_len};
        ADDR_RES_LOW:  s_axi_rdata <= {30'h0, result[1:0]};
        ADDR_RES_HIGH: s_axi_rdata <= {24'h0, result[9:2]};
        ADDR_STATUS:   s_axi_rdata <= {29'h0, active, state};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // power and interrupt outputs; idle does not stop the sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power <= '0;
    end else begin
      power.powered <= active;
      power.irq     <= converter_control[CTL_IRQ] && conv_irq_enable;
      power.wake    <= idle_mode && converter_control[CTL_IRQ] && conv_irq_enable;
    end
  end

endmodule // sarseq_top
`default_nettype wire
